// ---- hw/clock_gen.sv ----
// Purpose: Adjustable clock generator producing the alternative prescaler source.
// Assumes: Runs on clk_sys; output is a registered square wave in that domain.
// Notes: Mode changes are expected only while the generator is disabled.
`timescale 1ns/1ps
`default_nettype none
module clock_gen (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire wt_pkg::clock_gen_mode_t mode,
   input wire logic [wt_pkg::REG_W-1:0] compare,
   output logic generator_output_clock,
   output logic generator_rise
);
   import wt_pkg::*;
   logic run;
   logic [CGIN_DIV_W-1:0] in_div_r;
   logic [CGIN_DIV_W-1:0] in_mask;
   logic in_tick;
   logic [REG_W-1:0] half_r;
   logic [REG_W-1:0] half_last;
   // ==========================================================
   // Input clock selection
   assign run = mode.generator_enable && !mode.generator_output_disable;
   always_comb begin
      unique case (mode.generator_input_select)
         2'h0: in_mask = CGIN_MASK_DIV1;
         2'h1: in_mask = CGIN_MASK_DIV2;
         2'h2: in_mask = CGIN_MASK_DIV4;
         2'h3: in_mask = CGIN_MASK_DIV8;
      endcase
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         in_div_r <= '0;
      end else if (!run) begin
         in_div_r <= '0;
      end else begin
         in_div_r <= in_div_r + CGIN_MASK_DIV2;
      end
   end
   assign in_tick = (in_div_r & in_mask) == in_mask;
   // ==========================================================
   // Half-period counter
   // Zero minus one wraps to all ones, so a zero compare counts 256 inputs.
   assign half_last = compare - CMP_ONE;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         half_r <= '0;
      end else if (!run) begin
         half_r <= '0;
      end else if (in_tick) begin
         half_r <= (half_r == half_last) ? '0 : half_r + CMP_ONE;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         generator_output_clock <= 1'b0;
         generator_rise <= 1'b0;
      end else if (!run) begin
         generator_output_clock <= 1'b0;
         generator_rise <= 1'b0;
      end else begin
         generator_rise <= 1'b0;
         if (in_tick && half_r == half_last) begin
            generator_output_clock <= !generator_output_clock;
            generator_rise <= !generator_output_clock;
         end
      end
   end
endmodule // clock_gen
`default_nettype wire

// ---- hw/watch_timer.sv ----
// Purpose: Watch timer with interval function and adjustable clock generator.
// Assumes: Memory-mapped slave with word addresses; every access takes one wait state.
// Notes: Interrupt outputs are one-cycle pulses; the system controller latches them.
`timescale 1ns/1ps
`default_nettype none
module watch_timer (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [wt_pkg::BUS_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [wt_pkg::BUS_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [wt_pkg::BUS_W-1:0] readdata,
   output logic waitrequest,
   output logic watch_interrupt,
   output logic interval_interrupt,
   output logic generator_output_clock
);
   import wt_pkg::*;

   // ==========================================================
   // Declarations
   watch_mode_t watch_mode_control_r;
   clock_gen_mode_t clock_gen_mode_r;
   logic [REG_W-1:0] clock_gen_divide_compare_r;
   logic [MAIN_DIV_W-1:0] main_div_r;
   logic main_tick_r;
   logic gen_rise;
   logic src_tick;
   logic [PRESC_W-1:0] presc_r;
   logic [PRESC_W-1:0] ivl_mask;
   logic [PRESC_W-1:0] tap_mask;
   logic [3:0] tap_exp;
   logic tap_tick;
   logic ivl_hit;
   logic [WCNT_W-1:0] wcnt_r;
   logic [WCNT_W-1:0] wcnt_last;
   logic watch_run;
   logic req;
   logic take;
   logic done;
   logic byte0;
   logic hit_wmc;
   logic hit_cgm;
   logic hit_cmp;
   logic [REG_W-1:0] rd_byte;

   // ==========================================================
   // Helpers
   // Builds a mask of the n lowest prescaler bits.
   function automatic logic [PRESC_W-1:0] low_mask(input logic [3:0] n);
      logic [PRESC_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRESC_W; i++) begin
         m[i] = (i < int'(n));
      end
      return m;
   endfunction

   // ==========================================================
   // Main clock divided by 256
   // Free running, so the first source tick after a start can come anywhere within the next 256 cycles.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         main_div_r <= '0;
      end else begin
         main_div_r <= main_div_r + MAIN_DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         main_tick_r <= 1'b0;
      end else begin
         main_tick_r <= (main_div_r == MAIN_DIV_LAST);
      end
   end

   // ==========================================================
   // Clock generator
   clock_gen u_clock_gen (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .mode(clock_gen_mode_r),
      .compare(clock_gen_divide_compare_r),
      .generator_output_clock(generator_output_clock),
      .generator_rise(gen_rise)
   );

   // ==========================================================
   // Prescaler source
   always_comb begin
      if (watch_mode_control_r.source_select_bit) begin
         src_tick = gen_rise;
      end else begin
         src_tick = main_tick_r;
      end
   end

   // ==========================================================
   // 11-bit prescaler
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         presc_r <= '0;
      end else if (!watch_mode_control_r.global_enable) begin
         presc_r <= '0;
      end else if (src_tick) begin
         presc_r <= presc_r + PRESC_W'(1);
      end
   end

   // ==========================================================
   // Interval function
   assign ivl_mask = low_mask(INTERVAL_EXP_BASE
                              + {1'b0, watch_mode_control_r.interval_select});
   assign ivl_hit = watch_mode_control_r.global_enable && src_tick
                    && ((presc_r & ivl_mask) == ivl_mask);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         interval_interrupt <= 1'b0;
      end else begin
         interval_interrupt <= ivl_hit;
      end
   end

   // ==========================================================
   // Watch function tap
   // The fast settings count every source tick; a 16-count wrap gives 2^4.
   always_comb begin
      unique case (watch_mode_control_r.watch_period_select)
         2'h0: begin
            tap_exp = WATCH_TAP_EXP_00;
            wcnt_last = WCNT_LAST_FULL;
         end
         2'h1: begin
            tap_exp = WATCH_TAP_EXP_01;
            wcnt_last = WCNT_LAST_FULL;
         end
         2'h2: begin
            tap_exp = WATCH_TAP_EXP_FAST;
            wcnt_last = WCNT_LAST_FULL;
         end
         2'h3: begin
            tap_exp = WATCH_TAP_EXP_FAST;
            wcnt_last = WCNT_LAST_HALF;
         end
      endcase
   end

   assign tap_mask = low_mask(tap_exp);
   assign watch_run = watch_mode_control_r.global_enable
                      && watch_mode_control_r.watch_function_enable;
   assign tap_tick = watch_run && src_tick
                     && ((presc_r & tap_mask) == tap_mask);

   // ==========================================================
   // 5-bit watch counter
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wcnt_r <= '0;
      end else if (!watch_run) begin
         wcnt_r <= '0;
      end else if (tap_tick) begin
         if (wcnt_r == wcnt_last) begin
            wcnt_r <= '0;
         end else begin
            wcnt_r <= wcnt_r + WCNT_ONE;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         watch_interrupt <= 1'b0;
      end else begin
         watch_interrupt <= tap_tick && (wcnt_r == wcnt_last);
      end
   end

   // ==========================================================
   // Bus handshake
   // One wait state per access lets read data come straight from a flop.
   assign req = read || write;
   assign take = req && waitrequest;
   assign done = req && !waitrequest;
   assign byte0 = byteenable[0];
   assign hit_wmc = (address == IDX_WATCH_MODE_CONTROL);
   assign hit_cgm = (address == IDX_CLOCK_GEN_MODE);
   assign hit_cmp = (address == IDX_CLOCK_GEN_DIVIDE_COMPARE);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !take;
      end
   end

   // ==========================================================
   // Register writes
   // Bit manipulation arrives as a read-modify-write of the whole byte.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         watch_mode_control_r <= RST_WATCH_MODE_CONTROL;
      end else if (done && write && byte0 && hit_wmc) begin
         watch_mode_control_r <= writedata[REG_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clock_gen_mode_r <= RST_CLOCK_GEN_MODE;
      end else if (done && write && byte0 && hit_cgm) begin
         clock_gen_mode_r <= writedata[REG_W-1:0] & CLOCK_GEN_MODE_WMASK;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clock_gen_divide_compare_r <= RST_CLOCK_GEN_DIVIDE_COMPARE;
      end else if (done && write && byte0 && hit_cmp) begin
         clock_gen_divide_compare_r <= writedata[REG_W-1:0];
      end
   end

   // ==========================================================
   // Register reads
   // Unmapped addresses read zero and ignore writes.
   always_comb begin
      if (hit_wmc) begin
         rd_byte = watch_mode_control_r;
      end else if (hit_cgm) begin
         rd_byte = clock_gen_mode_r & CLOCK_GEN_MODE_WMASK;
      end else if (hit_cmp) begin
         rd_byte = clock_gen_divide_compare_r;
      end else begin
         rd_byte = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         readdata <= '0;
      end else if (take && read) begin
         readdata <= {{(BUS_W-REG_W){1'b0}}, rd_byte};
      end
   end
endmodule // watch_timer
`default_nettype wire

// ---- hw/wt_pkg.sv ----
// Purpose: Shared constants and types for the watch timer and its clock generator.
// Assumes: One 100 MHz clock, clk_sys; registers sit at word addresses on the bus.
// Notes: Rules that the block and its software keep.
// Function
// - Source select picks main clock divided by 256, or generator output.
// - Interval field picks prescaler period from 2^4 to 2^11 source cycles.
// - Watch field gives periods 2^14, 2^13, 2^5, 2^4 source cycles.
// - Watch enable low stops watch function and clears the 5-bit counter.
// - Watch enable high runs the watch function only while global enable is high.
// - Global enable low stops both interval and watch functions, clearing prescaler and 5-bit counter.
// - Global enable high starts the 11-bit prescaler and interval function.
// - Mode control register accepts bit-wise and whole-byte writes.
// - Compare register is 8-bit read/write and sets the generator divide factor.
// - Generator output toggles only when enabled and not disabled, else low.
// - Input select gives generator clock of main, /2, /4 or /8.
// - Generator output half-period is N generator input cycles.
// - Compare value zero acts as divide factor 256.
// - Watch interrupt pulses on each 5-bit counter overflow.
// - Interval interrupt pulses on every selected prescaler tap period.
package wt_pkg;
   // ==========================================================
   // Register map
   localparam int BUS_W = 32;
   localparam int REG_W = 8;
   localparam logic [BUS_W-1:0] IDX_WATCH_MODE_CONTROL = 32'hFFFFF360;
   localparam logic [BUS_W-1:0] IDX_CLOCK_GEN_MODE = 32'hFFFFF368;
   localparam logic [BUS_W-1:0] IDX_CLOCK_GEN_DIVIDE_COMPARE = 32'hFFFFF36A;
   localparam logic [REG_W-1:0] RST_WATCH_MODE_CONTROL = 8'h00;
   localparam logic [REG_W-1:0] RST_CLOCK_GEN_MODE = 8'h00;
   localparam logic [REG_W-1:0] RST_CLOCK_GEN_DIVIDE_COMPARE = 8'h00;
   localparam logic [REG_W-1:0] CLOCK_GEN_MODE_WMASK = 8'h17;
   // ==========================================================
   // Field layouts
   typedef struct packed {
      logic source_select_bit;
      logic [2:0] interval_select;
      logic [1:0] watch_period_select;
      logic watch_function_enable;
      logic global_enable;
   } watch_mode_t;
   typedef struct packed {
      logic [2:0] unused_hi;
      logic generator_enable;
      logic unused_3;
      logic generator_output_disable;
      logic [1:0] generator_input_select;
   } clock_gen_mode_t;
   // ==========================================================
   // Counter geometry
   localparam int MAIN_DIV_W = 8;
   localparam logic [MAIN_DIV_W-1:0] MAIN_DIV_LAST = 8'hFF;
   localparam int PRESC_W = 11;
   localparam logic [3:0] INTERVAL_EXP_BASE = 4'h4;
   localparam logic [3:0] WATCH_TAP_EXP_00 = 4'h9;
   localparam logic [3:0] WATCH_TAP_EXP_01 = 4'h8;
   localparam logic [3:0] WATCH_TAP_EXP_FAST = 4'h0;
   localparam int WCNT_W = 5;
   localparam logic [WCNT_W-1:0] WCNT_LAST_FULL = 5'h1F;
   localparam logic [WCNT_W-1:0] WCNT_LAST_HALF = 5'h0F;
   localparam logic [WCNT_W-1:0] WCNT_ONE = 5'h01;
   localparam int CGIN_DIV_W = 3;
   localparam logic [CGIN_DIV_W-1:0] CGIN_MASK_DIV1 = 3'h0;
   localparam logic [CGIN_DIV_W-1:0] CGIN_MASK_DIV2 = 3'h1;
   localparam logic [CGIN_DIV_W-1:0] CGIN_MASK_DIV4 = 3'h3;
   localparam logic [CGIN_DIV_W-1:0] CGIN_MASK_DIV8 = 3'h7;
   localparam logic [REG_W-1:0] CMP_ONE = 8'h01;
endpackage

// ---- tb/watch_timer_props.sv ----
// Purpose: Bus and output checks for watch_timer.
// Assumes: A register write lands on the edge that sees waitrequest low.
// Notes: Shadows of two registers are rebuilt from the writes seen on the bus.
`timescale 1ns/1ps
`default_nettype none
module watch_timer_props
   import wt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [wt_pkg::BUS_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [wt_pkg::BUS_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [wt_pkg::BUS_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic watch_interrupt,
   input wire logic interval_interrupt,
   input wire logic generator_output_clock
);
   // ==========================================
   // Register shadows
   logic [7:0] wm_r;
   logic [7:0] gm_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wm_r <= 8'h00;
         gm_r <= 8'h00;
      end else if (write && !waitrequest && byteenable[0]) begin
         if (address == IDX_WATCH_MODE_CONTROL) wm_r <= writedata[7:0];
         if (address == IDX_CLOCK_GEN_MODE) gm_r <= writedata[7:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ==========================================
   // Properties
   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("answer missing after one wait cycle");
   wait_short_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held too long");
   wait_cause_a: assert property (!waitrequest |-> $past(read) || $past(write))
      else $error("answer without request");
   upper_zero_a: assert property (readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   mode_zero_a: assert property (!waitrequest && read && address == IDX_CLOCK_GEN_MODE
      |-> (readdata[7:0] & 8'hE8) == 8'h00)
      else $error("unused mode bits read nonzero");
   gen_low_a: assert property ((!(gm_r[4] && !gm_r[2])) [*3] |-> !generator_output_clock)
      else $error("generator output not held low");
   irq_quiet_a: assert property (!wm_r[0] [*3] |-> !interval_interrupt && !watch_interrupt)
      else $error("interrupt while stopped");
   watch_off_a: assert property (!wm_r[1] [*3] |-> !watch_interrupt)
      else $error("watch pulse while disabled");
   irq_pulse_a: assert property ($rose(interval_interrupt) |=> $fell(interval_interrupt))
      else $error("interval pulse too long");
   watch_pulse_a: assert property (watch_interrupt |=> !watch_interrupt [*8])
      else $error("watch pulses too close");
   cover property (interval_interrupt);
   cover property (watch_interrupt);
   cover property ($rose(generator_output_clock));
endmodule // watch_timer_props
bind watch_timer watch_timer_props u_props (.clk_sys(clk_sys), .nrst(nrst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .watch_interrupt(watch_interrupt), .interval_interrupt(interval_interrupt),
   .generator_output_clock(generator_output_clock));
`default_nettype wire

// ---- tb/watch_timer_test.sv ----
// Purpose: Register-level test of watch_timer.
// Assumes: Generator at compare 1 and full rate ticks the prescaler every 2 cycles.
// Notes: The two slow watch codes are timed once from a clean start to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module watch_timer_test;
   import wt_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [BUS_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [BUS_W-1:0] writedata = '0;
   logic [3:0] byteenable = 4'hF;
   logic [BUS_W-1:0] readdata;
   logic waitrequest, watch_interrupt, interval_interrupt, generator_output_clock;
   logic sel_w = 1'b0;
   wire logic ev = sel_w ? watch_interrupt : interval_interrupt;
   int n_errors = 0;
   int check_count = 0;
   int wcnt = 0, icnt = 0, ghc = 0, n;
   int wsel[2] = '{3, 2};
   int wexp[2] = '{32, 64};
   logic [7:0] q;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (watch_interrupt === 1'b1) wcnt++;
      if (interval_interrupt === 1'b1) icnt++;
      if (generator_output_clock !== 1'b0) ghc++;
   end
   watch_timer uut (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .watch_interrupt(watch_interrupt),
      .interval_interrupt(interval_interrupt),
      .generator_output_clock(generator_output_clock));
   // ==========================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= {24'h000000, d};
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task wr(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [31:0] a, input logic [7:0] e, input string m);
      bus(1'b0, a, 8'h00);
      chk({24'h000000, q}, {24'h000000, e}, m);
   endtask
   // Clears only the enable bits in m, so no other field moves while running.
   task halt(input logic [31:0] a, input logic [7:0] m);
      bus(1'b0, a, 8'h00);
      bus(1'b1, a, q & m);
   endtask
   // Counts cycles up to the next pulse; the bound keeps a dead output from hanging.
   task wev(output int c);
      c = 0;
      do begin
         @(posedge clk_sys);
         c++;
      end while (ev !== 1'b1 && c < 70000);
   endtask
   task per(input logic w, output int c);
      sel_w = w;
      wev(c);
      wev(c);
   endtask
   task ghi(output int c);
      int k;
      k = 0;
      c = 0;
      while (generator_output_clock === 1'b1 && k < 5000) begin
         @(posedge clk_sys);
         k++;
      end
      while (generator_output_clock !== 1'b1 && k < 5000) begin
         @(posedge clk_sys);
         k++;
      end
      while (generator_output_clock === 1'b1 && c < 5000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask
   task test_done;
      $display("Errors: %0d, checks: %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      // Sized above the total run time of the tests, so only a hang reaches it.
      #900_000;
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done;
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(IDX_WATCH_MODE_CONTROL, 8'h00, "mode reset");
      rd(IDX_CLOCK_GEN_MODE, 8'h00, "gen mode reset");
      rd(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h00, "compare reset");
      rd(32'hFFFFF361, 8'h00, "unmapped read");
      wr(IDX_CLOCK_GEN_MODE, 8'hFF);
      rd(IDX_CLOCK_GEN_MODE, 8'h17, "gen mode mask");
      halt(IDX_CLOCK_GEN_MODE, 8'hEF);
      wr(IDX_CLOCK_GEN_MODE, 8'h00);
      byteenable <= 4'hE;
      wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'hA5);
      byteenable <= 4'hF;
      rd(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h00, "masked write");
      wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'hA5);
      rd(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'hA5, "compare");
      wr(IDX_WATCH_MODE_CONTROL, 8'hFE);
      rd(IDX_WATCH_MODE_CONTROL, 8'hFE, "mode byte");
      wr(IDX_WATCH_MODE_CONTROL, q | 8'h01);
      rd(IDX_WATCH_MODE_CONTROL, 8'hFF, "mode bit set");
      halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
      {icnt, wcnt, ghc} = '0;
      repeat (600) @(posedge clk_sys);
      chk(icnt + wcnt + ghc, 0, "idle outputs");
      for (int s = 0; s < 4; s++) begin
         halt(IDX_CLOCK_GEN_MODE, 8'hEF);
         wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h01);
         wr(IDX_CLOCK_GEN_MODE, 8'h10 | 8'(s));
         ghi(n);
         chk(n, 1 << s, "input select");
      end
      halt(IDX_CLOCK_GEN_MODE, 8'hEF);
      wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h00);
      wr(IDX_CLOCK_GEN_MODE, 8'h10);
      ghi(n);
      chk(n, 256, "zero compare");
      halt(IDX_CLOCK_GEN_MODE, 8'hEF);
      wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h03);
      wr(IDX_CLOCK_GEN_MODE, 8'h10);
      ghi(n);
      chk(n, 3, "half period");
      halt(IDX_CLOCK_GEN_MODE, 8'hEF);
      wr(IDX_CLOCK_GEN_DIVIDE_COMPARE, 8'h01);
      wr(IDX_CLOCK_GEN_MODE, 8'h14);
      ghc = 0;
      repeat (50) @(posedge clk_sys);
      chk(ghc, 0, "output disabled");
      halt(IDX_CLOCK_GEN_MODE, 8'hEF);
      wr(IDX_CLOCK_GEN_MODE, 8'h10);
      for (int k = 0; k < 8; k++) begin
         halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
         wr(IDX_WATCH_MODE_CONTROL, 8'h81 | 8'(k << 4));
         wcnt = 0;
         per(1'b0, n);
         chk(n, 32 << k, "interval period");
         chk(wcnt, 0, "watch stopped");
      end
      halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
      wr(IDX_WATCH_MODE_CONTROL, 8'h01);
      per(1'b0, n);
      chk(n, 4096, "main source");
      for (int j = 0; j < 2; j++) begin
         halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
         wr(IDX_WATCH_MODE_CONTROL, 8'h83 | 8'(wsel[j] << 2));
         per(1'b1, n);
         chk(n, wexp[j], "watch period");
      end
      // The generator starts last, so the first tick lands a fixed time after the write.
      for (int j = 0; j < 2; j++) begin
         halt(IDX_CLOCK_GEN_MODE, 8'hEF);
         halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
         wr(IDX_WATCH_MODE_CONTROL, 8'h83 | 8'(j << 2));
         wr(IDX_CLOCK_GEN_MODE, 8'h10);
         sel_w = 1'b1;
         wev(n);
         chk(n, (2 << (14 - j)) + 1, "watch from start");
      end
      halt(IDX_WATCH_MODE_CONTROL, 8'hFE);
      wr(IDX_WATCH_MODE_CONTROL, 8'h8E);
      {icnt, wcnt} = '0;
      repeat (200) @(posedge clk_sys);
      chk(icnt + wcnt, 0, "watch needs global");
      wr(IDX_WATCH_MODE_CONTROL, 8'h8F);
      {icnt, wcnt} = '0;
      repeat (200) @(posedge clk_sys);
      chk(32'(icnt > 0 && wcnt > 0), 1, "started");
      wr(IDX_WATCH_MODE_CONTROL, 8'h8D);
      repeat (3) @(posedge clk_sys);
      {icnt, wcnt} = '0;
      repeat (200) @(posedge clk_sys);
      chk(wcnt, 0, "watch stop");
      chk(32'(icnt > 0), 1, "interval runs on");
      test_done;
   end
endmodule // watch_timer_test
`default_nettype wire
